//--- common/spgo_pkg.sv
// constants for the spi pin general-purpose output block
// assumes a 32-bit avalon-mm register port and twelve spi pins
package spgo_pkg;
    // register byte addresses
    localparam logic [3:0] OFF_FUNC_SEL = 4'h0;
    localparam logic [3:0] OFF_DIR      = 4'h4;
    localparam logic [3:0] OFF_LEVEL    = 4'h8;
    localparam logic [3:0] OFF_SET      = 4'hc;

    // field layout of every pin register
    localparam int PIN_W        = 12;
    localparam int BIT_SLV_OUT  = 11;
    localparam int BIT_SLV_IN   = 10;
    localparam int BIT_SCLK     = 9;
    localparam int BIT_HS_EN    = 8;
    localparam int CS_MSB       = 7;
    localparam int CS_LSB       = 0;
    localparam int CS_W         = 8;
    localparam int LANE0_W      = 8;
    localparam int LANE1_W      = 4;

    // reset values
    localparam logic [11:0] RST_FUNC_SEL = 12'h000;
    localparam logic [11:0] RST_DIR      = 12'h000;
    localparam logic [11:0] RST_LEVEL    = 12'h000;
    localparam logic [31:0] RST_RDATA    = 32'h0000_0000;

    // cycles from a register change to the pins
    localparam int PIN_LAT = 1;

    // bus handshake states, gray along idle -> ack
    typedef enum logic [0:0] {
        SPGO_IDLE = 1'b0,
        SPGO_ACK  = 1'b1
    } spgo_bus_st_t;
endpackage

//--- core/spgo_bus.sv
// avalon-mm slave handshake: one wait cycle, registered read data
// assumes the master holds its request until waitrequest is low
`timescale 1ns/100ps
module spgo_bus (
    // clock and reset
    input  wire logic        i_mclk,
    input  wire logic        i_rst,
    // avalon request
    input  wire logic        i_avs_read,
    input  wire logic        i_avs_write,
    output logic             o_avs_waitrequest,
    output logic [31:0]      o_avs_readdata,
    // register file side
    input  wire logic [31:0] i_rd_data,
    output logic             o_wr_fire,
    output logic             o_rd_fire
);
    spgo_pkg::spgo_bus_st_t state_reg;
    spgo_pkg::spgo_bus_st_t state_next;
    logic                   req;

    assign req = i_avs_read | i_avs_write;

    always_comb begin
        state_next = state_reg;
        unique case (state_reg)
            spgo_pkg::SPGO_IDLE: begin
                if (req) begin
                    state_next = spgo_pkg::SPGO_ACK;
                end
            end
            spgo_pkg::SPGO_ACK: begin
                state_next = spgo_pkg::SPGO_IDLE;
            end
        endcase
    end

    always_ff @(posedge i_mclk) begin
        if (i_rst) begin
            state_reg <= spgo_pkg::SPGO_IDLE;
        end else begin
            state_reg <= state_next;
        end
    end

    // read data is caught while waitrequest is still high
    always_ff @(posedge i_mclk) begin
        if (i_rst) begin
            o_avs_readdata <= spgo_pkg::RST_RDATA;
        end else if (state_reg == spgo_pkg::SPGO_IDLE && i_avs_read) begin
            o_avs_readdata <= i_rd_data;
        end
    end

    assign o_avs_waitrequest = req && state_reg != spgo_pkg::SPGO_ACK;
    assign o_wr_fire         = i_avs_write && state_reg == spgo_pkg::SPGO_ACK;
    assign o_rd_fire         = i_avs_read && state_reg == spgo_pkg::SPGO_ACK;
endmodule

//--- core/spgo_pin_drv.sv
// registered pin drivers for the twelve spi pins
// assumes the spi core leaves a pin alone while its enable here is high
`timescale 1ns/100ps
module spgo_pin_drv (
    // clock and reset
    input  wire logic        i_mclk,
    input  wire logic        i_rst,
    // pin configuration
    input  wire logic [11:0] i_level,
    input  wire logic [11:0] i_func_sel,
    input  wire logic [11:0] i_dir,
    // pin side
    output logic [11:0]      o_pin_out,
    output logic [11:0]      o_pin_oe
);
    logic [11:0] drive;

    // a pin is ours only as a general-purpose output
    assign drive = i_func_sel & i_dir;

    always_ff @(posedge i_mclk) begin
        if (i_rst) begin
            o_pin_oe <= '0;
        end else begin
            o_pin_oe <= drive;
        end
    end

    // level is forced low on pins not driven, so nothing leaks out
    always_ff @(posedge i_mclk) begin
        if (i_rst) begin
            o_pin_out <= '0;
        end else begin
            o_pin_out <= i_level & drive;
        end
    end
endmodule

//--- core/spgo_top.sv
// spi pin general-purpose output registers with avalon-mm access
// assumes an avalon-mm master on i_mclk and pins sampled on i_mclk
//
// The register addresses and the Avalon-MM register port were decided locally.
`timescale 1ns/100ps

// Notes on behaviour
// R1: bit 11 drives slave-out pin as output
// R2: bit 10 drives slave-in pin as output
// R3: bit 9 drives serial clock as output
// R4: bit 8 drives handshake enable as output
// R5: bits 7-0 drive chip-select pins
// R6: software keeps absent chip-select bits zero
// R7: bits 31-12 read zero, writes ignored
// R8: level bits reset zero, read/write
// R9: set register writes of one set levels
// R10: reads return stored levels regardless of pins; the set register reads back the pin levels instead
module spgo_top (
    // clock and reset
    input  wire logic        i_mclk,
    input  wire logic        i_rst,
    // avalon-mm slave
    input  wire logic [3:0]  i_avs_address,
    input  wire logic        i_avs_read,
    input  wire logic        i_avs_write,
    input  wire logic [31:0] i_avs_writedata,
    input  wire logic [3:0]  i_avs_byteenable,
    output logic             o_avs_waitrequest,
    output logic [31:0]      o_avs_readdata,
    // slave-out pin
    input  wire logic        i_slave_out_pin,
    output logic             o_slave_out_pin,
    output logic             o_slave_out_pin_oe,
    // slave-in pin
    input  wire logic        i_slave_in_pin,
    output logic             o_slave_in_pin,
    output logic             o_slave_in_pin_oe,
    // serial clock pin
    input  wire logic        i_serial_clock_pin,
    output logic             o_serial_clock_pin,
    output logic             o_serial_clock_pin_oe,
    // handshake enable pin
    input  wire logic        i_handshake_enable_pin,
    output logic             o_handshake_enable_pin,
    output logic             o_handshake_enable_pin_oe,
    // chip-select pins
    input  wire logic [7:0]  i_chip_select_pin,
    output logic [7:0]       o_chip_select_pin,
    output logic [7:0]       o_chip_select_pin_oe
);
    logic [11:0] func_sel_reg;
    logic [11:0] dir_reg;
    logic [11:0] pin_output_level_reg;
    logic [11:0] pin_output_level_next;
    logic [11:0] pin_in;
    logic [11:0] pin_out;
    logic [11:0] pin_oe;
    logic [31:0] rd_data;
    logic        wr_fire;
    logic        rd_fire;
    logic [11:0] wr_mask;
    logic [11:0] wr_bits;

    // byte lanes 0 and 1 cover the twelve live bits
    function automatic logic [11:0] lane_mask(input logic [3:0] be);
        lane_mask = {{spgo_pkg::LANE1_W{be[1]}}, {spgo_pkg::LANE0_W{be[0]}}};
    endfunction

    // masked merge of a write into a pin register
    function automatic logic [11:0] merge(input logic [11:0] old_val,
                                          input logic [11:0] new_val,
                                          input logic [11:0] mask);
        merge = (old_val & ~mask) | (new_val & mask);
    endfunction

    function automatic logic hit(input logic [3:0] addr, input logic [3:0] off);
        hit = addr == off;
    endfunction

    spgo_bus u_bus (
        .i_mclk            (i_mclk),
        .i_rst             (i_rst),
        .i_avs_read        (i_avs_read),
        .i_avs_write       (i_avs_write),
        .o_avs_waitrequest (o_avs_waitrequest),
        .o_avs_readdata    (o_avs_readdata),
        .i_rd_data         (rd_data),
        .o_wr_fire         (wr_fire),
        .o_rd_fire         (rd_fire)
    );

    // R7: upper bits never stored
    assign wr_bits = i_avs_writedata[spgo_pkg::PIN_W-1:0];
    assign wr_mask = lane_mask(i_avs_byteenable);

    always_ff @(posedge i_mclk) begin
        if (i_rst) begin
            func_sel_reg <= spgo_pkg::RST_FUNC_SEL;
        end else if (wr_fire && hit(i_avs_address, spgo_pkg::OFF_FUNC_SEL)) begin
            func_sel_reg <= merge(func_sel_reg, wr_bits, wr_mask);
        end
    end

    always_ff @(posedge i_mclk) begin
        if (i_rst) begin
            dir_reg <= spgo_pkg::RST_DIR;
        end else if (wr_fire && hit(i_avs_address, spgo_pkg::OFF_DIR)) begin
            dir_reg <= merge(dir_reg, wr_bits, wr_mask);
        end
    end

    always_comb begin
        pin_output_level_next = pin_output_level_reg;
        if (wr_fire && hit(i_avs_address, spgo_pkg::OFF_LEVEL)) begin
            pin_output_level_next = merge(pin_output_level_reg, wr_bits, wr_mask);
        end else if (wr_fire && hit(i_avs_address, spgo_pkg::OFF_SET)) begin
            // R9: ones set, zeros keep
            pin_output_level_next = pin_output_level_reg | (wr_bits & wr_mask);
        end
    end

    // R8: level bits reset to zero
    always_ff @(posedge i_mclk) begin
        if (i_rst) begin
            pin_output_level_reg <= spgo_pkg::RST_LEVEL;
        end else begin
            pin_output_level_reg <= pin_output_level_next;
        end
    end

    assign pin_in = {i_slave_out_pin, i_slave_in_pin, i_serial_clock_pin,
                     i_handshake_enable_pin, i_chip_select_pin};

    // R10: level reads show the stored bits
    always_comb begin
        rd_data = '0;
        if (hit(i_avs_address, spgo_pkg::OFF_FUNC_SEL)) begin
            rd_data[spgo_pkg::PIN_W-1:0] = func_sel_reg;
        end else if (hit(i_avs_address, spgo_pkg::OFF_DIR)) begin
            rd_data[spgo_pkg::PIN_W-1:0] = dir_reg;
        end else if (hit(i_avs_address, spgo_pkg::OFF_LEVEL)) begin
            rd_data[spgo_pkg::PIN_W-1:0] = pin_output_level_reg;
        end else if (hit(i_avs_address, spgo_pkg::OFF_SET)) begin
            // the set register reads back the pin levels
            rd_data[spgo_pkg::PIN_W-1:0] = pin_in;
        end
    end

    // R1: drive only as general-purpose output
    spgo_pin_drv u_drv (
        .i_mclk     (i_mclk),
        .i_rst      (i_rst),
        .i_level    (pin_output_level_reg),
        .i_func_sel (func_sel_reg),
        .i_dir      (dir_reg),
        .o_pin_out  (pin_out),
        .o_pin_oe   (pin_oe)
    );

    // R2: slave-in and the other pins split out
    assign o_slave_out_pin           = pin_out[spgo_pkg::BIT_SLV_OUT];
    assign o_slave_out_pin_oe        = pin_oe[spgo_pkg::BIT_SLV_OUT];
    assign o_slave_in_pin            = pin_out[spgo_pkg::BIT_SLV_IN];
    assign o_slave_in_pin_oe         = pin_oe[spgo_pkg::BIT_SLV_IN];
    // R3: serial clock pin
    assign o_serial_clock_pin        = pin_out[spgo_pkg::BIT_SCLK];
    assign o_serial_clock_pin_oe     = pin_oe[spgo_pkg::BIT_SCLK];
    // R4: handshake enable pin
    assign o_handshake_enable_pin    = pin_out[spgo_pkg::BIT_HS_EN];
    assign o_handshake_enable_pin_oe = pin_oe[spgo_pkg::BIT_HS_EN];
    // R5: chip-select pins by index
    assign o_chip_select_pin         = pin_out[spgo_pkg::CS_MSB:spgo_pkg::CS_LSB];
    assign o_chip_select_pin_oe      = pin_oe[spgo_pkg::CS_MSB:spgo_pkg::CS_LSB];

    default clocking cb @(posedge i_mclk);
    endclocking
    default disable iff (i_rst);

    logic        req;
    logic [11:0] drive;
    assign req   = i_avs_read | i_avs_write;
    assign drive = func_sel_reg & dir_reg;

    sequence s_waiting;
        req && o_avs_waitrequest;
    endsequence

    sequence s_answered;
        req && !o_avs_waitrequest;
    endsequence

    sequence s_released;
        !wr_fire && !rd_fire;
    endsequence

    a_wait_one_cycle: assert property (s_waiting |=> s_answered)
        else $error("request not answered after one wait cycle");

    a_answer_releases: assert property (s_answered |=> s_released)
        else $error("second answer right after an answer");

    // R8: written value lands in the level register
    a_level_write: assert property ( // R8
        (wr_fire && hit(i_avs_address, spgo_pkg::OFF_LEVEL) && i_avs_byteenable[1:0] == 2'h3)
        |=> pin_output_level_reg == $past(wr_bits))
        else $error("level register did not take written value");

    // R8: reset leaves level bits at zero
    a_level_reset: assert property ( // R8
        @(posedge i_mclk) disable iff (1'b0)
        i_rst |=> pin_output_level_reg == spgo_pkg::RST_LEVEL)
        else $error("level register not zero after reset");

    // R9: set write ors ones in
    a_set_write: assert property ( // R9
        (wr_fire && hit(i_avs_address, spgo_pkg::OFF_SET))
        |=> pin_output_level_reg == ($past(pin_output_level_reg) | ($past(wr_bits) & $past(wr_mask))))
        else $error("set write did not or in the ones");

    // R7: upper bits read zero
    a_upper_zero: assert property ( // R7
        rd_fire |-> o_avs_readdata[31:spgo_pkg::PIN_W] == '0)
        else $error("reserved read bits not zero");

    // R10: level read returns stored bits
    a_level_read: assert property ( // R10
        (i_avs_read && hit(i_avs_address, spgo_pkg::OFF_LEVEL) && o_avs_waitrequest)
        |=> rd_fire && o_avs_readdata[spgo_pkg::PIN_W-1:0] == $past(pin_output_level_reg))
        else $error("level read differs from stored bits");

    // R1: slave-out follows its bit as gp output
    a_slave_out_drive: assert property ( // R1
        drive[spgo_pkg::BIT_SLV_OUT] |=> o_slave_out_pin_oe
        && o_slave_out_pin == $past(pin_output_level_reg[spgo_pkg::BIT_SLV_OUT]))
        else $error("slave-out pin not driven from its bit");

    // R1: slave-out released otherwise
    a_slave_out_float: assert property ( // R1
        !drive[spgo_pkg::BIT_SLV_OUT] |=> !o_slave_out_pin_oe && !o_slave_out_pin)
        else $error("slave-out pin driven while not gp output");

    // R2: slave-in follows its bit
    a_slave_in_drive: assert property ( // R2
        drive[spgo_pkg::BIT_SLV_IN] |=> o_slave_in_pin_oe
        && o_slave_in_pin == $past(pin_output_level_reg[spgo_pkg::BIT_SLV_IN]))
        else $error("slave-in pin not driven from its bit");

    // R3: serial clock follows its bit
    a_sclk_drive: assert property ( // R3
        drive[spgo_pkg::BIT_SCLK] |=> o_serial_clock_pin_oe
        && o_serial_clock_pin == $past(pin_output_level_reg[spgo_pkg::BIT_SCLK]))
        else $error("serial clock pin not driven from its bit");

    // R4: handshake enable follows its bit
    a_hs_en_drive: assert property ( // R4
        drive[spgo_pkg::BIT_HS_EN] |=> o_handshake_enable_pin_oe
        && o_handshake_enable_pin == $past(pin_output_level_reg[spgo_pkg::BIT_HS_EN]))
        else $error("handshake enable pin not driven from its bit");

    // R5: chip selects gated per pin
    a_cs_drive: assert property ( // R5
        1'b1 |=> o_chip_select_pin_oe == $past(drive[spgo_pkg::CS_MSB:spgo_pkg::CS_LSB])
        && o_chip_select_pin == $past(pin_output_level_reg[spgo_pkg::CS_MSB:spgo_pkg::CS_LSB]
        & drive[spgo_pkg::CS_MSB:spgo_pkg::CS_LSB]))
        else $error("chip-select pins not gated by their bits");

    // R10: level holds in every cycle without a write
    a_level_kept: assert property ( // R10
        (!wr_fire && !i_rst) |=> pin_output_level_reg == $past(pin_output_level_reg))
        else $error("level bits changed without a write");

    // R2: slave-in released otherwise
    a_slave_in_float: assert property ( // R2
        !drive[spgo_pkg::BIT_SLV_IN] |=> !o_slave_in_pin_oe && !o_slave_in_pin)
        else $error("slave-in pin driven while not gp output");

    // R3: serial clock released otherwise
    a_sclk_float: assert property ( // R3
        !drive[spgo_pkg::BIT_SCLK] |=> !o_serial_clock_pin_oe && !o_serial_clock_pin)
        else $error("serial clock pin driven while not gp output");

    // R4: handshake enable released otherwise
    a_hs_en_float: assert property ( // R4
        !drive[spgo_pkg::BIT_HS_EN] |=> !o_handshake_enable_pin_oe && !o_handshake_enable_pin)
        else $error("handshake enable pin driven while not gp output");

    // R8: each byte lane of a level write lands on its own
    a_level_lanes: assert property ( // R8
        (wr_fire && hit(i_avs_address, spgo_pkg::OFF_LEVEL))
        |=> pin_output_level_reg[spgo_pkg::CS_MSB:spgo_pkg::CS_LSB]
            == ($past(i_avs_byteenable[0]) ? $past(i_avs_writedata[spgo_pkg::CS_MSB:spgo_pkg::CS_LSB])
                : $past(pin_output_level_reg[spgo_pkg::CS_MSB:spgo_pkg::CS_LSB]))
        && pin_output_level_reg[spgo_pkg::BIT_SLV_OUT:spgo_pkg::BIT_HS_EN]
            == ($past(i_avs_byteenable[1]) ? $past(i_avs_writedata[spgo_pkg::BIT_SLV_OUT:spgo_pkg::BIT_HS_EN])
                : $past(pin_output_level_reg[spgo_pkg::BIT_SLV_OUT:spgo_pkg::BIT_HS_EN])))
        else $error("level write lanes not applied one by one");

    // R9: a set write never clears a level bit
    a_set_keeps: assert property ( // R9
        (wr_fire && hit(i_avs_address, spgo_pkg::OFF_SET))
        |=> (pin_output_level_reg & $past(pin_output_level_reg)) == $past(pin_output_level_reg))
        else $error("set write cleared a level bit");

    // R1: function select takes its written value
    a_func_write: assert property ( // R1
        (wr_fire && hit(i_avs_address, spgo_pkg::OFF_FUNC_SEL) && i_avs_byteenable[1:0] == 2'h3)
        |=> func_sel_reg == $past(i_avs_writedata[spgo_pkg::PIN_W-1:0]))
        else $error("function select did not take written value");

    // R1: direction takes its written value
    a_dir_write: assert property ( // R1
        (wr_fire && hit(i_avs_address, spgo_pkg::OFF_DIR) && i_avs_byteenable[1:0] == 2'h3)
        |=> dir_reg == $past(i_avs_writedata[spgo_pkg::PIN_W-1:0]))
        else $error("direction did not take written value");

    // R10: read data stands until the next read
    a_rdata_held: assert property ( // R10
        !(i_avs_read && o_avs_waitrequest) |=> $stable(o_avs_readdata))
        else $error("read data changed without a read");
endmodule

//--- bench/spgo_tb.sv
// self-checking testbench for the spi pin general-purpose output block
// assumes spgo_top with one wait cycle on the bus and pins one edge after the register
`timescale 1ns/100ps
module tb;
    logic        i_mclk;
    logic        i_rst;
    logic [3:0]  avs_address;
    logic        avs_read;
    logic        avs_write;
    logic [31:0] avs_writedata;
    logic [3:0]  avs_byteenable;
    logic        o_avs_waitrequest;
    logic [31:0] o_avs_readdata;
    logic [11:0] pin_in;
    logic [11:0] pin_out;
    logic [11:0] pin_oe;
    logic [31:0] rd;
    int          errors;
    int          samples_checked;

    spgo_top i_dut (
        .i_mclk                    (i_mclk),
        .i_rst                     (i_rst),
        .i_avs_address             (avs_address),
        .i_avs_read                (avs_read),
        .i_avs_write               (avs_write),
        .i_avs_writedata           (avs_writedata),
        .i_avs_byteenable          (avs_byteenable),
        .o_avs_waitrequest         (o_avs_waitrequest),
        .o_avs_readdata            (o_avs_readdata),
        .i_slave_out_pin           (pin_in[11]),
        .o_slave_out_pin           (pin_out[11]),
        .o_slave_out_pin_oe        (pin_oe[11]),
        .i_slave_in_pin            (pin_in[10]),
        .o_slave_in_pin            (pin_out[10]),
        .o_slave_in_pin_oe         (pin_oe[10]),
        .i_serial_clock_pin        (pin_in[9]),
        .o_serial_clock_pin        (pin_out[9]),
        .o_serial_clock_pin_oe     (pin_oe[9]),
        .i_handshake_enable_pin    (pin_in[8]),
        .o_handshake_enable_pin    (pin_out[8]),
        .o_handshake_enable_pin_oe (pin_oe[8]),
        .i_chip_select_pin         (pin_in[7:0]),
        .o_chip_select_pin         (pin_out[7:0]),
        .o_chip_select_pin_oe      (pin_oe[7:0])
    );

    initial i_mclk = 1'b0;
    always #10 i_mclk = ~i_mclk;

    task automatic final_report();
        $display("checks %0d mismatches %0d", samples_checked, errors);
        if (errors == 0 && samples_checked > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    task automatic check_reg(input logic [31:0] got, input logic [31:0] exp, input string what);
        samples_checked++;
        if (got !== exp) begin
            errors++;
            $display("MISMATCH %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask

    // pins are looked at one edge after the register has taken its new value
    task automatic check_pins(input logic [11:0] exp_out, input logic [11:0] exp_oe);
        @(posedge i_mclk);
        #1;
        samples_checked++;
        if (pin_out !== exp_out || pin_oe !== exp_oe) begin
            errors++;
            $display("MISMATCH %0t pins out %h oe %h exp %h %h", $time, pin_out, pin_oe, exp_out, exp_oe);
        end
    endtask

    // one avalon transfer: held until waitrequest is seen low at a rising edge
    task automatic bus_xfer(input logic wr, input logic [3:0] a, input logic [31:0] d, input logic [3:0] be,
                            output logic [31:0] q);
        @(posedge i_mclk);
        avs_address    <= a;
        avs_writedata  <= d;
        avs_byteenable <= be;
        avs_read       <= ~wr;
        avs_write      <= wr;
        #1;
        // a hang here is ended by the watchdog
        while (o_avs_waitrequest !== 1'b0) begin
            @(posedge i_mclk);
            #1;
        end
        // the edge at which waitrequest is sampled low: data taken, request released
        @(posedge i_mclk);
        q = o_avs_readdata;
        avs_read  <= 1'b0;
        avs_write <= 1'b0;
    endtask

    task automatic wr32(input logic [3:0] a, input logic [31:0] d, input logic [3:0] be);
        logic [31:0] q;
        bus_xfer(1'b1, a, d, be, q);
    endtask

    task automatic rd32(input logic [3:0] a, output logic [31:0] q);
        bus_xfer(1'b0, a, 32'h0000_0000, 4'hf, q);
    endtask

    task automatic t_reset();
        check_pins(12'h000, 12'h000);
        rd32(spgo_pkg::OFF_LEVEL, rd);
        check_reg(rd, 32'h0000_0000, "level reset");
        $display("test reset done");
    endtask

    task automatic t_reserved();
        wr32(spgo_pkg::OFF_LEVEL, 32'hffff_ffff, 4'hf);
        rd32(spgo_pkg::OFF_LEVEL, rd);
        check_reg(rd, 32'h0000_0fff, "level upper bits");
        wr32(spgo_pkg::OFF_LEVEL, 32'hffff_f000, 4'hf);
        rd32(spgo_pkg::OFF_LEVEL, rd);
        check_reg(rd, 32'h0000_0000, "level cleared");
        wr32(spgo_pkg::OFF_LEVEL, 32'h0000_0aaa, 4'h2);
        rd32(spgo_pkg::OFF_LEVEL, rd);
        check_reg(rd, 32'h0000_0a00, "level lane1 only");
        $display("test reserved done");
    endtask

    // each level bit reaches exactly its own pin
    task automatic t_walk();
        // all eight chip selects are present, so every bit may be written
        wr32(spgo_pkg::OFF_FUNC_SEL, 32'h0000_0fff, 4'hf);
        wr32(spgo_pkg::OFF_DIR, 32'h0000_0fff, 4'hf);
        for (int i = 0; i < 12; i++) begin
            wr32(spgo_pkg::OFF_LEVEL, 32'h0000_0001 << i, 4'hf);
            check_pins(12'h001 << i, 12'hfff);
        end
        $display("test walk done");
    endtask

    // a pin is driven only while it is general-purpose and an output
    task automatic t_gate();
        wr32(spgo_pkg::OFF_FUNC_SEL, 32'h0000_05a5, 4'hf);
        wr32(spgo_pkg::OFF_DIR, 32'h0000_03cf, 4'hf);
        wr32(spgo_pkg::OFF_LEVEL, 32'h0000_0fff, 4'hf);
        check_pins(12'h185, 12'h185);
        wr32(spgo_pkg::OFF_FUNC_SEL, 32'h0000_0a5a, 4'hf);
        check_pins(12'h24a, 12'h24a);
        rd32(spgo_pkg::OFF_LEVEL, rd);
        check_reg(rd, 32'h0000_0fff, "level under gating");
        $display("test gate done");
    endtask

    task automatic t_set();
        wr32(spgo_pkg::OFF_LEVEL, 32'h0000_0001, 4'hf);
        wr32(spgo_pkg::OFF_SET, 32'h0000_0900, 4'hf);
        rd32(spgo_pkg::OFF_LEVEL, rd);
        check_reg(rd, 32'h0000_0901, "set ones");
        wr32(spgo_pkg::OFF_SET, 32'h0000_0000, 4'hf);
        rd32(spgo_pkg::OFF_LEVEL, rd);
        check_reg(rd, 32'h0000_0901, "set zeros");
        wr32(spgo_pkg::OFF_SET, 32'h0000_0fff, 4'h1);
        rd32(spgo_pkg::OFF_LEVEL, rd);
        check_reg(rd, 32'h0000_09ff, "set lane0 only");
        rd32(spgo_pkg::OFF_SET, rd);
        check_reg(rd, 32'h0000_0c3a, "set reads pins");
        $display("test set done");
    endtask

    task automatic t_unmapped();
        wr32(4'h2, 32'h0000_0000, 4'hf);
        rd32(spgo_pkg::OFF_LEVEL, rd);
        check_reg(rd, 32'h0000_09ff, "unmapped write");
        rd32(4'h2, rd);
        check_reg(rd, 32'h0000_0000, "unmapped read");
        $display("test unmapped done");
    endtask

    initial begin
        #100000;
        errors++;
        $display("MISMATCH %0t watchdog expired", $time);
        final_report();
    end

    initial begin
        i_rst          = 1'b1;
        avs_address    = 4'h0;
        avs_read       = 1'b0;
        avs_write      = 1'b0;
        avs_writedata  = 32'h0000_0000;
        avs_byteenable = 4'h0;
        pin_in         = 12'hc3a;
        errors          = 0;
        samples_checked = 0;
        repeat (8) @(posedge i_mclk);
        i_rst <= 1'b0;
        @(posedge i_mclk);
        t_reset();
        t_reserved();
        t_walk();
        t_gate();
        t_set();
        t_unmapped();
        final_report();
    end
endmodule
